//--- hdl/ssf_pkg.sv
/*
 * constants of the socket status and force-event register bank:
 * register offsets, field positions, reset values, states and timing.
 * assumes a 125 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none
package ssf_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] OFS_PRESENT = 8'h08;
    localparam logic [7:0] OFS_FORCE = 8'h0C;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_UNRECOG = 7;
    localparam int POS_IRQ = 6;
    localparam int POS_WIDE = 5;
    localparam int POS_NARROW = 4;
    localparam int POS_POWERED = 3;
    localparam int POS_DET_B = 2;
    localparam int POS_DET_A = 1;
    localparam int POS_STSCHG = 0;
    localparam int POS_LOST = 8;
    localparam int POS_BADSUP = 9;
    localparam int POS_VCAP_LO = 10;
    localparam int POS_VCAP_HI = 13;
    localparam int POS_REINT = 14;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] RST_SOCKET_CAPS = 32'h3000_0000;
    localparam logic [3:0] RST_VCAP = 4'h0;
    localparam logic [1:0] RST_DETECT = 2'h3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 125;
    localparam int INTERROG_NS = 1000;
    localparam int INTERROG_CYC = (INTERROG_NS * CLK_MHZ) / 1000;

    // ************************************************************
    // interrogation states
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROBE = 2'b01,
        ST_LATCH = 2'b10
    } ssf_state_t;
endpackage
`default_nettype wire

//--- hdl/ssf_regs.sv
/*
 * socket present-state and force-event registers behind an APB slave,
 * with a small card interrogation sequencer.
 * assumes card identification results arrive on the system clock and
 * that socket pins and the bus reset are asynchronous.
 */
// Functional notes
// - unrecognized-card flag sets on unknown card, cleared only by a wide or narrow identification or a context clear.
// - bit 6 shows the live card interrupt line level.
// - bit 5 wide-bus card flag changes only at interrogation, by force or by context clear.
// - bit 4 narrow card flag changes only at interrogation, by force or by context clear.
// - bit 3 follows the outcome of the socket power request.
// - bits 2 and 1 mirror detect pins, frozen during interrogation.
// - bit 0 mirrors the status-change pin level.
// - context bits cleared by global reset, or bus reset when wake disabled.
// - force register bits 31 to 15 and 6 read zero.
// - force bit 14 re-interrogates the card and re-enables auto power.
// - force bits 13 to 10 set voltage caps and disable auto power unless bit 14 is also set.
// - force bit 9 sets the invalid-supply-request flag.
// - force bits 8, 7, 5, 4 set lost-data, unrecognized, wide, narrow flags.
// - force bit 3 raises the power event, powered flag untouched.
// - force bits 2, 1 raise detect events, detect levels untouched.
// - force bit 0 raises the status-change event, level untouched.
// - voltage caps and card type refresh only at insertion or by force.
`default_nettype none
module ssf_regs #(
    parameter int PROBE_CYCLES = ssf_pkg::INTERROG_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic PME_ENABLE,
    input wire logic BUS_RESET_PIN,
    input wire logic CARD_IRQ_PIN,
    input wire logic DETECT_A_PIN,
    input wire logic DETECT_B_PIN,
    input wire logic STATUS_CHANGE_PIN,
    input wire logic SOCKET_POWER_UP,
    input wire logic ID_WIDE,
    input wire logic ID_NARROW,
    input wire logic ID_UNKNOWN,
    input wire logic [3:0] ID_VCAP,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic PROBE_ACTIVE,
    output logic AUTO_POWER_EN,
    output logic [3:0] EVENT_PULSE
);
    // ************************************************************
    // checks and declarations
    // ************************************************************
    if (PROBE_CYCLES < 1 || PROBE_CYCLES > 65535) begin : g_bad_probe
        $error("ssf_regs: PROBE_CYCLES out of range");
    end

    logic bus_rst, irq_lvl, sts_lvl;
    logic [1:0] det_lvl;
    ssf_pkg::ssf_state_t state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic card_in_r, card_in_nxt;
    logic probe_r, probe_nxt;
    logic unrecog_r, unrecog_nxt, wide_r, wide_nxt, narrow_r, narrow_nxt;
    logic lost_r, lost_nxt, badsup_r, badsup_nxt, powered_r, powered_nxt;
    logic irq_r, irq_nxt, sts_r, sts_nxt, auto_r, auto_nxt;
    logic [1:0] det_r, det_nxt;
    logic [3:0] vcap_r, vcap_nxt, evt_r, evt_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic wr_force, ctx_clr, inserted;
    logic [31:0] present_word;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    ssf_sync #(.WIDTH(5), .INIT(5'h06)) u_sync (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CE),
        .din({BUS_RESET_PIN, CARD_IRQ_PIN, DETECT_B_PIN, DETECT_A_PIN, STATUS_CHANGE_PIN}),
        .dout({bus_rst, irq_lvl, det_lvl, sts_lvl})
    );

    // ************************************************************
    // interrogation sequencer
    // ************************************************************
    assign wr_force = PSEL && PENABLE && pready_r && PWRITE && hit(PADDR, ssf_pkg::OFS_FORCE);
    assign ctx_clr = bus_rst && !PME_ENABLE;
    assign inserted = !card_in_r && (det_lvl == 2'b00);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        card_in_nxt = (det_lvl == 2'b00);
        case (state_r)
            ssf_pkg::ST_IDLE: begin
                if (inserted || (wr_force && PWDATA[ssf_pkg::POS_REINT])) begin
                    state_nxt = ssf_pkg::ST_PROBE;
                    cnt_nxt = 16'(PROBE_CYCLES - 1);
                end
            end
            ssf_pkg::ST_PROBE: begin
                if (cnt_r == 16'h0000) state_nxt = ssf_pkg::ST_LATCH;
                else cnt_nxt = cnt_r - 16'h0001;
            end
            ssf_pkg::ST_LATCH: state_nxt = ssf_pkg::ST_IDLE;
            default: state_nxt = ssf_pkg::ST_IDLE;
        endcase
        // registered so the probe flag leaves straight from a flip-flop
        probe_nxt = (state_nxt == ssf_pkg::ST_PROBE);
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state_r <= ssf_pkg::ST_IDLE;
            cnt_r <= 16'h0000;
            card_in_r <= 1'b0;
            probe_r <= 1'b0;
        end else if (CE) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            card_in_r <= card_in_nxt;
            probe_r <= probe_nxt;
        end
    end

    // ************************************************************
    // status bits
    // ************************************************************
    always_comb begin
        unrecog_nxt = unrecog_r;
        wide_nxt = wide_r;
        narrow_nxt = narrow_r;
        vcap_nxt = vcap_r;
        lost_nxt = lost_r;
        badsup_nxt = badsup_r;
        auto_nxt = auto_r;
        evt_nxt = 4'h0;
        irq_nxt = irq_lvl;
        sts_nxt = sts_lvl;
        powered_nxt = SOCKET_POWER_UP;
        det_nxt = (state_r == ssf_pkg::ST_IDLE) ? det_lvl : det_r;
        if (state_r == ssf_pkg::ST_LATCH) begin
            wide_nxt = ID_WIDE;
            narrow_nxt = ID_NARROW;
            vcap_nxt = ID_VCAP;
            if (ID_UNKNOWN) unrecog_nxt = 1'b1;
            else if (ID_WIDE || ID_NARROW) unrecog_nxt = 1'b0;
        end
        if (ctx_clr) begin
            unrecog_nxt = 1'b0;
            wide_nxt = 1'b0;
            narrow_nxt = 1'b0;
            vcap_nxt = ssf_pkg::RST_VCAP;
            lost_nxt = 1'b0;
            badsup_nxt = 1'b0;
            powered_nxt = 1'b0;
            det_nxt = ssf_pkg::RST_DETECT;
        end
        // software forcing: a one sets, a zero leaves alone
        if (wr_force) begin
            vcap_nxt = vcap_r | PWDATA[ssf_pkg::POS_VCAP_HI:ssf_pkg::POS_VCAP_LO];
            if (|PWDATA[ssf_pkg::POS_VCAP_HI:ssf_pkg::POS_VCAP_LO]) auto_nxt = 1'b0;
            if (PWDATA[ssf_pkg::POS_REINT]) auto_nxt = 1'b1;
            if (PWDATA[ssf_pkg::POS_BADSUP]) badsup_nxt = 1'b1;
            if (PWDATA[ssf_pkg::POS_LOST]) lost_nxt = 1'b1;
            if (PWDATA[ssf_pkg::POS_UNRECOG]) unrecog_nxt = 1'b1;
            if (PWDATA[ssf_pkg::POS_WIDE]) wide_nxt = 1'b1;
            if (PWDATA[ssf_pkg::POS_NARROW]) narrow_nxt = 1'b1;
            evt_nxt = PWDATA[ssf_pkg::POS_POWERED:ssf_pkg::POS_STSCHG];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            unrecog_r <= 1'b0;
            wide_r <= 1'b0;
            narrow_r <= 1'b0;
            vcap_r <= ssf_pkg::RST_VCAP;
            lost_r <= 1'b0;
            badsup_r <= 1'b0;
            powered_r <= 1'b0;
            det_r <= ssf_pkg::RST_DETECT;
            irq_r <= 1'b0;
            sts_r <= 1'b0;
            auto_r <= 1'b1;
            evt_r <= 4'h0;
        end else if (CE) begin
            unrecog_r <= unrecog_nxt;
            wide_r <= wide_nxt;
            narrow_r <= narrow_nxt;
            vcap_r <= vcap_nxt;
            lost_r <= lost_nxt;
            badsup_r <= badsup_nxt;
            powered_r <= powered_nxt;
            det_r <= det_nxt;
            irq_r <= irq_nxt;
            sts_r <= sts_nxt;
            auto_r <= auto_nxt;
            evt_r <= evt_nxt;
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    always_comb begin
        present_word = ssf_pkg::RST_SOCKET_CAPS;
        present_word[ssf_pkg::POS_VCAP_HI:ssf_pkg::POS_VCAP_LO] = vcap_r;
        present_word[ssf_pkg::POS_BADSUP] = badsup_r;
        present_word[ssf_pkg::POS_LOST] = lost_r;
        present_word[ssf_pkg::POS_UNRECOG] = unrecog_r;
        present_word[ssf_pkg::POS_IRQ] = irq_r;
        present_word[ssf_pkg::POS_WIDE] = wide_r;
        present_word[ssf_pkg::POS_NARROW] = narrow_r;
        present_word[ssf_pkg::POS_POWERED] = powered_r;
        present_word[ssf_pkg::POS_DET_B:ssf_pkg::POS_DET_A] = det_r;
        present_word[ssf_pkg::POS_STSCHG] = sts_r;
    end

    // answer one cycle after the setup phase
    always_comb begin
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h0000_0000;
        if (PSEL && !PENABLE) begin
            pready_nxt = 1'b1;
            if (hit(PADDR, ssf_pkg::OFS_PRESENT)) begin
                if (!PWRITE) prdata_nxt = present_word;
            end else if (hit(PADDR, ssf_pkg::OFS_FORCE)) begin
                prdata_nxt = 32'h0000_0000;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (CE) begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PROBE_ACTIVE = probe_r;
    assign AUTO_POWER_EN = auto_r;
    assign EVENT_PULSE = evt_r;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_reint_write;
        CE && wr_force && PWDATA[ssf_pkg::POS_REINT] && state_r == ssf_pkg::ST_IDLE;
    endsequence
    sequence s_probe_then_latch;
        CE && state_r == ssf_pkg::ST_LATCH;
    endsequence

    chk_irq_mirror: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE |=> irq_r == $past(irq_lvl)) else $error("irq level not mirrored");
    chk_sts_mirror: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE |=> sts_r == $past(sts_lvl)) else $error("status-change level not mirrored");
    chk_det_frozen: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE && state_r != ssf_pkg::ST_IDLE && !ctx_clr |=> $stable(det_r)) else $error("detect moved in probe");
    chk_type_stable: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE && state_r != ssf_pkg::ST_LATCH && !wr_force && !ctx_clr |=> $stable(wide_r) && $stable(narrow_r))
        else $error("card type changed outside interrogation");
    chk_unrecog_set: assert property (@(posedge SYS_CLK) disable iff (RESET)
        s_probe_then_latch ##0 (ID_UNKNOWN && !ctx_clr) |=> unrecog_r) else $error("unknown card not flagged");
    chk_reint_probe: assert property (@(posedge SYS_CLK) disable iff (RESET)
        s_reint_write |=> PROBE_ACTIVE && AUTO_POWER_EN) else $error("re-interrogation not started");
    chk_vcap_auto: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE && wr_force && |PWDATA[ssf_pkg::POS_VCAP_HI:ssf_pkg::POS_VCAP_LO] && !PWDATA[ssf_pkg::POS_REINT]
        |=> !AUTO_POWER_EN) else $error("auto power not disabled");
    chk_event_pulse: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE && wr_force |=> EVENT_PULSE == $past(PWDATA[ssf_pkg::POS_POWERED:ssf_pkg::POS_STSCHG]))
        else $error("forced event not raised");
    chk_ctx_clear: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE && ctx_clr && !wr_force |=> !unrecog_r && !lost_r && !badsup_r && vcap_r == ssf_pkg::RST_VCAP)
        else $error("context bits not cleared");
    chk_force_zero: assert property (@(posedge SYS_CLK) disable iff (RESET)
        CE && PSEL && !PENABLE && !PWRITE && hit(PADDR, ssf_pkg::OFS_FORCE) |=> PREADY && PRDATA == 32'h0)
        else $error("force register read not zero");
endmodule // ssf_regs
`default_nettype wire

//--- hdl/ssf_sync.sv
/*
 * three-stage input synchroniser with agreement filter.
 * assumes inputs asynchronous to clk; output changes when stages two and three agree.
 */
`default_nettype none
module ssf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
    logic [WIDTH-1:0] out_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("ssf_sync: WIDTH must be at least 1");
    end

    // stage one feeds stage two only
    always_comb begin
        out_nxt = out_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) out_nxt[i] = s3_r[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            out_r <= INIT;
        end else if (ce) begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule // ssf_sync
`default_nettype wire

//--- sim/ssf_card_model.sv
/*
 * behavioural model of the card standing in the socket: pins and identification results.
 * assumes the same clock as the register bank; levels change just after a rising edge.
 */
`default_nettype none
module ssf_card_model (
    input wire logic clk,
    input wire logic inserted,
    input wire logic irq_lvl,
    input wire logic sts_lvl,
    input wire logic [1:0] kind,
    input wire logic [3:0] vcap,
    output logic irq_pin,
    output logic det_a_pin,
    output logic det_b_pin,
    output logic sts_pin,
    output logic id_wide,
    output logic id_narrow,
    output logic id_unknown,
    output logic [3:0] id_vcap
);
    // ************************************************************
    // pins: detect lines pulled up, irq and status pulled down when empty
    // ************************************************************
    initial begin
        {irq_pin, sts_pin, id_wide, id_narrow, id_unknown, id_vcap} = '0;
        {det_a_pin, det_b_pin} = 2'h3;
    end
    always @(posedge clk) begin
        det_a_pin <= ~inserted;
        det_b_pin <= ~inserted;
        irq_pin <= inserted & irq_lvl;
        sts_pin <= inserted & sts_lvl;
        id_wide <= inserted & (kind == 2'h1);
        id_narrow <= inserted & (kind == 2'h2);
        id_unknown <= inserted & (kind == 2'h0);
        id_vcap <= inserted ? vcap : 4'h0;
    end
endmodule // ssf_card_model
`default_nettype wire

//--- sim/tb_socket_status_force_regs.sv
/*
 * self-checking bench of the socket status and force-event register bank.
 * assumes ssf_pkg, ssf_regs and the card model are compiled first.
 */
`default_nettype none
module tb_socket_status_force_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_PS = ssf_pkg::OFS_PRESENT;
    localparam logic [7:0] A_FC = ssf_pkg::OFS_FORCE;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic pme = 1'b0, bus_rst = 1'b0, power_up = 1'b0;
    logic inserted = 1'b0, irq_lvl = 1'b0, sts_lvl = 1'b0;
    logic [1:0] kind = 2'h1;
    logic [3:0] vcap = 4'h0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, probe_active, auto_power_en, err;
    logic [3:0] event_pulse;
    logic irq_pin, det_a_pin, det_b_pin, sts_pin, id_wide, id_narrow, id_unknown;
    logic [3:0] id_vcap;
    int num_errors = 0;
    int comparisons = 0;
    always #4 clk = ~clk;

    ssf_regs #(.PROBE_CYCLES(4)) DUT (.SYS_CLK(clk), .RESET(rst), .CE(ce), .PME_ENABLE(pme),
        .BUS_RESET_PIN(bus_rst), .CARD_IRQ_PIN(irq_pin), .DETECT_A_PIN(det_a_pin), .DETECT_B_PIN(det_b_pin),
        .STATUS_CHANGE_PIN(sts_pin), .SOCKET_POWER_UP(power_up), .ID_WIDE(id_wide), .ID_NARROW(id_narrow),
        .ID_UNKNOWN(id_unknown), .ID_VCAP(id_vcap), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PROBE_ACTIVE(probe_active), .AUTO_POWER_EN(auto_power_en), .EVENT_PULSE(event_pulse));
    ssf_card_model card (.clk(clk), .inserted(inserted), .irq_lvl(irq_lvl), .sts_lvl(sts_lvl), .kind(kind),
        .vcap(vcap), .irq_pin(irq_pin), .det_a_pin(det_a_pin), .det_b_pin(det_b_pin), .sts_pin(sts_pin),
        .id_wide(id_wide), .id_narrow(id_narrow), .id_unknown(id_unknown), .id_vcap(id_vcap));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic complete_run;
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task automatic check_bits(input logic [3:0] got, input logic [3:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        check_word(rd, exp, msg);
    endtask
    task automatic wait_probe;
        int n;
        logic seen;
        seen = 1'b0;
        n = 0;
        comparisons++;
        while (!seen && n < 40) begin
            @(posedge clk);
            n++;
            seen = (probe_active === 1'b1);
        end
        while (probe_active !== 1'b0 && n < 80) begin
            @(posedge clk);
            n++;
        end
        if (!seen || n >= 80) begin
            num_errors++;
            complete_run();
        end
        repeat (2) @(posedge clk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        rd_check(A_PS, 32'h3000_0006, "present after reset");
        rd_check(A_FC, 32'h0, "force readback");
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        check_word({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, A_PS, 32'hFFFF_FFFF);
        rd_check(A_PS, 32'h3000_0006, "present is read-only");
        check_word({31'h0, auto_power_en}, 32'h1, "auto power at reset");
    endtask
    task automatic t_insert;
        @(posedge clk);
        power_up <= 1'b1;
        irq_lvl <= 1'b1;
        kind <= 2'h1;
        vcap <= 4'h3;
        inserted <= 1'b1;
        wait_probe();
        repeat (8) @(posedge clk);
        rd_check(A_PS, 32'h3000_0C68, "wide card inserted");
        irq_lvl <= 1'b0;
        sts_lvl <= 1'b1;
        kind <= 2'h0;
        vcap <= 4'h1;
        repeat (8) @(posedge clk);
        rd_check(A_PS, 32'h3000_0C29, "live levels, type held");
    endtask
    task automatic t_reinterrogate;
        apb(1'b1, A_FC, 32'h0000_4000);
        wait_probe();
        rd_check(A_PS, 32'h3000_0489, "unknown card");
        apb(1'b1, A_FC, 32'h0000_1000);
        @(posedge clk);
        check_word({31'h0, auto_power_en}, 32'h0, "auto power off");
        rd_check(A_PS, 32'h3000_1489, "forced voltage cap");
        kind <= 2'h2;
        vcap <= 4'h2;
        apb(1'b1, A_FC, 32'h0000_4000);
        @(posedge clk);
        check_word({31'h0, auto_power_en}, 32'h1, "auto power back on");
        wait_probe();
        rd_check(A_PS, 32'h3000_0819, "narrow card");
    endtask
    task automatic t_force;
        apb(1'b1, A_FC, 32'hFFFF_83B0);
        @(posedge clk);
        check_bits(event_pulse, 4'h0, "no event from flag bits");
        rd_check(A_PS, 32'h3000_0BB9, "forced flags");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_FC, 32'h1 << i);
            @(posedge clk);
            check_bits(event_pulse, 4'h1 << i, "forced event");
            @(posedge clk);
            check_bits(event_pulse, 4'h0, "event pulse ends");
        end
        rd_check(A_PS, 32'h3000_0BB9, "levels untouched");
        apb(1'b1, A_FC, 32'h0);
        @(posedge clk);
        check_bits(event_pulse, 4'h0, "zero write");
        rd_check(A_PS, 32'h3000_0BB9, "zero write keeps flags");
        rd_check(A_FC, 32'h0, "force reads zero");
    endtask
    task automatic t_context;
        inserted <= 1'b0;
        repeat (8) @(posedge clk);
        rd_check(A_PS, 32'h3000_0BBE, "removal keeps type");
        pme <= 1'b1;
        bus_rst <= 1'b1;
        repeat (6) @(posedge clk);
        bus_rst <= 1'b0;
        repeat (8) @(posedge clk);
        rd_check(A_PS, 32'h3000_0BBE, "bus reset with wake on");
        pme <= 1'b0;
        bus_rst <= 1'b1;
        repeat (6) @(posedge clk);
        bus_rst <= 1'b0;
        repeat (8) @(posedge clk);
        rd_check(A_PS, 32'h3000_000E, "bus reset with wake off");
        power_up <= 1'b0;
        repeat (3) @(posedge clk);
        rd_check(A_PS, 32'h3000_0006, "powered down");
        apb(1'b1, A_FC, 32'h0000_4000);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        check_word({31'h0, probe_active}, 32'h1, "probe frozen by clock enable");
        ce <= 1'b1;
        wait_probe();
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_insert();
        t_reinterrogate();
        t_force();
        t_context();
        complete_run();
    end
endmodule // tb_socket_status_force_regs
`default_nettype wire
